/* File: acc_exec_pkg.sv */
package acc_exec_pkg;

  // ***************************************************************
  // Widths and bus answers
  // ***************************************************************
  localparam int         DATA_W      = 8;
  localparam int         FADDR_W     = 7;
  localparam int         PC_W        = 13;
  localparam int         SP_W        = 3;
  localparam int         STACK_DEPTH = 8;
  localparam int         AXI_ADDR_W  = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFF_INSTR      = 8'h00;
  localparam logic [7:0] OFF_ACC        = 8'h04;
  localparam logic [7:0] OFF_STATUS     = 8'h08;
  localparam logic [7:0] OFF_PC         = 8'h0C;
  localparam logic [7:0] OFF_STACK_TOP  = 8'h10;
  localparam logic [7:0] OFF_STACK_PUSH = 8'h14;
  localparam logic [7:0] OFF_FILE_ADDR  = 8'h18;
  localparam logic [7:0] OFF_FILE_DATA  = 8'h1C;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int INSTR_OP_LSB   = 0;
  localparam int INSTR_DEST_BIT = 4;
  localparam int INSTR_FA_LSB   = 8;
  localparam int INSTR_LIT_LSB  = 16;
  localparam int ST_ZERO_BIT    = 0;
  localparam int ST_CARRY_BIT   = 1;
  localparam int ST_GIE_BIT     = 2;
  localparam int ST_BUSY_BIT    = 3;
  localparam int ST_SP_LSB      = 8;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
  localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
  localparam logic               FLAG_RST  = 1'b0;

  // ***************************************************************
  // Operation codes, states and carriers
  // ***************************************************************
  typedef enum logic [3:0] {
    OP_NO_OPERATION    = 4'h0,
    OP_OR_LITERAL      = 4'h1,
    OP_OR_REGISTER     = 4'h2,
    OP_INCREMENT       = 4'h3,
    OP_MOVE_REGISTER   = 4'h4,
    OP_LOAD_LITERAL    = 4'h5,
    OP_STORE_ACC       = 4'h6,
    OP_RETURN_LITERAL  = 4'h7,
    OP_RETURN_INTERRUPT = 4'h8,
    OP_ROTATE_LEFT     = 4'h9
  } opcode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_EXEC  = 2'h2,
    ST_FLUSH = 2'h3
  } exec_state_t;

  typedef struct packed {
    logic [DATA_W-1:0]  literal;
    logic [FADDR_W-1:0] faddr;
    logic               dest;
    opcode_t            op;
  } instr_t;

  typedef struct packed {
    logic               we;
    logic [FADDR_W-1:0] waddr;
    logic [DATA_W-1:0]  wdata;
    logic [FADDR_W-1:0] raddr;
  } mem_req_t;

endpackage

/* File: accumulator_instruction_execute.sv */
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module accumulator_instruction_execute
  import acc_exec_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Core state
  output logic [DATA_W-1:0]          acc_value,
  output logic [PC_W-1:0]            pc_value,
  output logic                       global_interrupt_enable,
  output logic                       exec_busy
);

  // ***************************************************************
  // State
  // ***************************************************************
  exec_state_t        state_reg;
  instr_t             instr_reg;
  logic [DATA_W-1:0]  acc_reg;
  logic [PC_W-1:0]    pc_reg;
  logic               zero_reg;
  logic               carry_reg;
  logic               gie_reg;
  logic [FADDR_W-1:0] faddr_reg;
  logic [PC_W-1:0]    stack_reg [0:STACK_DEPTH-1];
  logic [SP_W-1:0]    sp_reg;
  logic [PC_W-1:0]    stack_top_entry;

  logic                  aw_full_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic                  w_full_reg;
  logic [31:0]           w_data_reg;
  logic [3:0]            w_strb_reg;
  logic                  rd_pend_reg;
  logic [AXI_ADDR_W-1:0] ar_addr_reg;

  logic [DATA_W-1:0] mem_rdata;
  mem_req_t          mem_req;
  logic              wr_fire;
  logic              wr_lane0;
  logic              wr_mapped;
  logic              rd_mapped;
  logic              idle;

  // Execution results.
  logic [DATA_W-1:0] result;
  logic              to_acc;
  logic              to_file;
  logic              upd_zero;
  logic              upd_carry;
  logic              new_carry;
  logic              is_return;

  assign idle            = (state_reg == ST_IDLE);
  assign stack_top_entry = stack_reg[sp_reg - 3'h1];

  // ***************************************************************
  // AXI4-Lite write path
  // ***************************************************************
  // Writes are held off while an instruction executes, so software never
  // races the datapath on the accumulator, flags or file registers.
  assign s_axi_awready = !aw_full_reg && idle;
  assign s_axi_wready  = !w_full_reg && idle;
  assign wr_fire       = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_lane0      = w_strb_reg[0];

  always_comb begin
    case (aw_addr_reg)
      OFF_INSTR, OFF_ACC, OFF_STATUS, OFF_PC, OFF_STACK_PUSH,
      OFF_FILE_ADDR, OFF_FILE_DATA: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // AXI4-Lite read path
  // ***************************************************************
  // A read is taken only while idle; its data leave one edge later so the
  // registered file-register read sees the address of the taken request.
  assign s_axi_arready = idle && !rd_pend_reg && !s_axi_rvalid;

  always_comb begin
    case (ar_addr_reg)
      OFF_INSTR, OFF_ACC, OFF_STATUS, OFF_PC, OFF_STACK_TOP,
      OFF_STACK_PUSH, OFF_FILE_ADDR, OFF_FILE_DATA: rd_mapped = 1'b1;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_reg <= 1'b0;
      ar_addr_reg <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_pend_reg <= 1'b1;
      ar_addr_reg <= s_axi_araddr;
    end else begin
      rd_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_pend_reg) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      case (ar_addr_reg)
        OFF_INSTR: s_axi_rdata <= {8'h00, instr_reg.literal, 1'h0,
          instr_reg.faddr, 3'h0, instr_reg.dest, instr_reg.op};
        OFF_ACC:       s_axi_rdata <= 32'(acc_reg);
        OFF_STATUS: begin
          s_axi_rdata               <= '0;
          s_axi_rdata[ST_ZERO_BIT]  <= zero_reg;
          s_axi_rdata[ST_CARRY_BIT] <= carry_reg;
          s_axi_rdata[ST_GIE_BIT]   <= gie_reg;
          s_axi_rdata[ST_BUSY_BIT]  <= !idle;
          s_axi_rdata[ST_SP_LSB +: SP_W] <= sp_reg;
        end
        OFF_PC:        s_axi_rdata <= 32'(pc_reg);
        OFF_STACK_TOP: s_axi_rdata <= 32'(stack_top_entry);
        OFF_FILE_ADDR: s_axi_rdata <= 32'(faddr_reg);
        OFF_FILE_DATA: s_axi_rdata <= 32'(mem_rdata);
        default:       s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // Instruction sequencer
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      instr_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_fire && wr_lane0 && aw_addr_reg == OFF_INSTR) begin
            instr_reg.op      <= opcode_t'(w_data_reg[INSTR_OP_LSB +: 4]);
            instr_reg.dest    <= w_data_reg[INSTR_DEST_BIT];
            instr_reg.faddr   <= w_data_reg[INSTR_FA_LSB +: FADDR_W];
            instr_reg.literal <= w_data_reg[INSTR_LIT_LSB +: DATA_W];
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: state_reg <= ST_EXEC;
        ST_EXEC:  state_reg <= is_return ? ST_FLUSH : ST_IDLE;
        ST_FLUSH: state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Datapath decode
  // ***************************************************************
  always_comb begin
    result    = '0;
    to_acc    = 1'b0;
    to_file   = 1'b0;
    upd_zero  = 1'b0;
    upd_carry = 1'b0;
    new_carry = carry_reg;
    is_return = 1'b0;
    case (instr_reg.op)
      OP_OR_LITERAL: begin
        result   = acc_reg | instr_reg.literal;
        to_acc   = 1'b1;
        upd_zero = 1'b1;
      end
      OP_OR_REGISTER: begin
        result   = acc_reg | mem_rdata;
        to_acc   = !instr_reg.dest;
        to_file  = instr_reg.dest;
        upd_zero = 1'b1;
      end
      OP_INCREMENT: begin
        result   = mem_rdata + 8'h01;
        to_acc   = !instr_reg.dest;
        to_file  = instr_reg.dest;
        upd_zero = 1'b1;
      end
      OP_MOVE_REGISTER: begin
        result   = mem_rdata;
        to_acc   = !instr_reg.dest;
        to_file  = instr_reg.dest;
        upd_zero = 1'b1;
      end
      OP_LOAD_LITERAL: begin
        result = instr_reg.literal;
        to_acc = 1'b1;
      end
      OP_STORE_ACC: begin
        result  = acc_reg;
        to_file = 1'b1;
      end
      OP_RETURN_LITERAL: begin
        result    = instr_reg.literal;
        to_acc    = 1'b1;
        is_return = 1'b1;
      end
      OP_RETURN_INTERRUPT: is_return = 1'b1;
      OP_ROTATE_LEFT: begin
        result    = {mem_rdata[DATA_W-2:0], carry_reg};
        new_carry = mem_rdata[DATA_W-1];
        upd_carry = 1'b1;
        to_acc    = !instr_reg.dest;
        to_file   = instr_reg.dest;
      end
      default: result = '0;
    endcase
  end

  // ***************************************************************
  // File-register port
  // ***************************************************************
  always_comb begin
    mem_req       = '0;
    mem_req.raddr = idle ? faddr_reg : instr_reg.faddr;
    if (state_reg == ST_EXEC && to_file) begin
      mem_req.we    = 1'b1;
      mem_req.waddr = instr_reg.faddr;
      mem_req.wdata = result;
    end else if (wr_fire && wr_lane0 && aw_addr_reg == OFF_FILE_DATA) begin
      mem_req.we    = 1'b1;
      mem_req.waddr = faddr_reg;
      mem_req.wdata = w_data_reg[DATA_W-1:0];
    end
  end

  file_reg_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (mem_req),
    .rdata   (mem_rdata)
  );

  // ***************************************************************
  // Accumulator, flags and file address
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= ACC_RST;
    end else if (state_reg == ST_EXEC && to_acc) begin
      acc_reg <= result;
    end else if (wr_fire && wr_lane0 && aw_addr_reg == OFF_ACC) begin
      acc_reg <= w_data_reg[DATA_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_reg  <= FLAG_RST;
      carry_reg <= FLAG_RST;
      gie_reg   <= FLAG_RST;
    end else if (state_reg == ST_EXEC) begin
      if (upd_zero) begin
        zero_reg <= (result == '0);
      end
      if (upd_carry) begin
        carry_reg <= new_carry;
      end
      if (instr_reg.op == OP_RETURN_INTERRUPT) begin
        gie_reg <= 1'b1;
      end
    end else if (wr_fire && wr_lane0 && aw_addr_reg == OFF_STATUS) begin
      zero_reg  <= w_data_reg[ST_ZERO_BIT];
      carry_reg <= w_data_reg[ST_CARRY_BIT];
      gie_reg   <= w_data_reg[ST_GIE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      faddr_reg <= FADDR_RST;
    end else if (wr_fire && wr_lane0 && aw_addr_reg == OFF_FILE_ADDR) begin
      faddr_reg <= w_data_reg[FADDR_W-1:0];
    end
  end

  // ***************************************************************
  // Program counter and return stack
  // ***************************************************************
  // The stack is circular: a pop below the bottom wraps, as in hardware.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg <= PC_RST;
      sp_reg <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_reg[i] <= PC_RST;
      end
    end else if (state_reg == ST_EXEC) begin
      if (is_return) begin
        pc_reg <= stack_top_entry;
        sp_reg <= sp_reg - 3'h1;
      end else begin
        pc_reg <= pc_reg + 13'h0001;
      end
    end else if (wr_fire && wr_lane0) begin
      if (aw_addr_reg == OFF_PC) begin
        pc_reg <= w_data_reg[PC_W-1:0];
      end else if (aw_addr_reg == OFF_STACK_PUSH) begin
        stack_reg[sp_reg] <= w_data_reg[PC_W-1:0];
        sp_reg            <= sp_reg + 3'h1;
      end
    end
  end

  assign acc_value               = acc_reg;
  assign pc_value                = pc_reg;
  assign global_interrupt_enable = gie_reg;
  assign exec_busy               = !idle;

endmodule
`default_nettype wire

/* File: accumulator_instruction_execute_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module accumulator_instruction_execute_assertions
  import acc_exec_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Register bus
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  // Core state
  input wire logic [DATA_W-1:0] acc_value,
  input wire logic [PC_W-1:0]   pc_value,
  input wire logic              global_interrupt_enable,
  input wire logic              exec_busy
);
  // ***************************************************************
  // Last write data word taken from the bus, split into instruction fields
  // ***************************************************************
  opcode_t           op_q;
  logic              dest_q;
  logic [DATA_W-1:0] lit_q;
  logic              is_ret;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_q   <= OP_NO_OPERATION;
      dest_q <= 1'h0;
      lit_q  <= 8'h00;
    end else if (s_axi_wvalid && s_axi_wready) begin
      op_q   <= opcode_t'(s_axi_wdata[3:0]);
      dest_q <= s_axi_wdata[INSTR_DEST_BIT];
      lit_q  <= s_axi_wdata[23:16];
    end
  end

  assign is_ret = (op_q == OP_RETURN_LITERAL) || (op_q == OP_RETURN_INTERRUPT);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence two_busy;
    exec_busy [*2] ##1 !exec_busy;
  endsequence
  sequence three_busy;
    exec_busy [*3] ##1 !exec_busy;
  endsequence

  short_exec_a: assert property (
    $rose(exec_busy) && !is_ret |-> two_busy)
    else $error("plain instruction not busy for two cycles");
  ret_flush_a: assert property (
    $rose(exec_busy) && is_ret |-> three_busy)
    else $error("return not busy for three cycles");
  pc_step_a: assert property (
    $fell(exec_busy) && !is_ret |-> pc_value == $past(pc_value, 3) + 13'h1)
    else $error("program counter did not advance by one");
  lit_load_a: assert property (
    $fell(exec_busy) && op_q inside {OP_LOAD_LITERAL, OP_RETURN_LITERAL}
    |-> acc_value == lit_q)
    else $error("accumulator does not hold the literal");
  or_lit_a: assert property (
    $fell(exec_busy) && op_q == OP_OR_LITERAL
    |-> acc_value == ($past(acc_value, 3) | lit_q))
    else $error("accumulator is not the OR with the literal");
  acc_keep_a: assert property (
    $fell(exec_busy) && (op_q inside {OP_STORE_ACC, OP_NO_OPERATION,
    OP_RETURN_INTERRUPT} || dest_q && op_q inside {OP_OR_REGISTER,
    OP_INCREMENT, OP_MOVE_REGISTER, OP_ROTATE_LEFT})
    |-> acc_value == $past(acc_value, 3))
    else $error("accumulator changed unexpectedly");
  gie_set_a: assert property (
    $fell(exec_busy) && op_q == OP_RETURN_INTERRUPT
    |-> global_interrupt_enable)
    else $error("interrupt enable not set by return");
  gie_keep_a: assert property (
    $fell(exec_busy) && op_q != OP_RETURN_INTERRUPT
    |-> global_interrupt_enable == $past(global_interrupt_enable, 3))
    else $error("interrupt enable changed unexpectedly");
  wr_answer_a: assert property (
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
    else $error("read data missing");
endmodule

bind accumulator_instruction_execute accumulator_instruction_execute_assertions
  chk_u (
  .aclk, .aresetn, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .acc_value, .pc_value, .global_interrupt_enable, .exec_busy
);
`default_nettype wire

/* File: accumulator_instruction_execute_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module accumulator_instruction_execute_tb_top
  import acc_exec_pkg::*;
;
  logic                  aclk;
  logic                  aresetn;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                  s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                  s_axi_rready, global_interrupt_enable, exec_busy;
  logic [DATA_W-1:0]     acc_value;
  logic [PC_W-1:0]       pc_value;
  logic [6:0]            fa = 7'h00;
  int                    num_errors, total_checks, cycles, busy_cnt;
  int                    busy_len;

  accumulator_instruction_execute dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .acc_value, .pc_value,
    .global_interrupt_enable, .exec_busy
  );

  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles++;
    if (exec_busy === 1'h1) busy_cnt++;
    if (cycles == 5000) begin
      num_errors++;
      $display("Error at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  // ***************************************************************
  // Bus and comparison tasks
  // ***************************************************************
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check(rdv, exp);
  endtask

  task automatic exec(input opcode_t op, input logic d,
                      input logic [6:0] f, input logic [7:0] lit);
    int n0;
    n0 = busy_cnt;
    axi_write(OFF_INSTR, {8'h00, lit, 1'h0, f, 3'h0, d, op});
    while (exec_busy !== 1'h0) @(posedge aclk);
    busy_len = busy_cnt - n0;
    @(negedge aclk);
  endtask

  // Each call uses a fresh file address and parks the file window elsewhere.
  task automatic t(input opcode_t op, input logic d, input logic [7:0] v,
                   input logic [7:0] a, input logic [1:0] st,
                   input logic [7:0] ea, input logic [7:0] ef,
                   input logic [1:0] es);
    logic [PC_W-1:0] pc0;
    fa = fa - 7'h01;
    axi_write(OFF_ACC, {24'h000000, a});
    axi_write(OFF_STATUS, {30'h00000000, st});
    axi_write(OFF_FILE_ADDR, {25'h0000000, fa});
    axi_write(OFF_FILE_DATA, {24'h000000, v});
    axi_write(OFF_FILE_ADDR, {25'h0000000, ~fa});
    pc0 = pc_value;
    exec(op, d, fa, v);
    check(busy_len, 32'h2);
    check(pc_value, pc0 + 13'h0001);
    check(acc_value, ea);
    rd_chk(OFF_STATUS, {30'h00000000, es});
    axi_write(OFF_FILE_ADDR, {25'h0000000, fa});
    rd_chk(OFF_FILE_DATA, {24'h000000, ef});
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(OFF_ACC, 32'h00000000);
    rd_chk(OFF_STATUS, 32'h00000000);
    rd_chk(OFF_PC, 32'h00000000);
    axi_read(8'h40);
    check(rsp, RESP_SLVERR);
    check(rdv, 32'h00000000);
    axi_write(8'h40, 32'h000000FF);
    check(rsp, RESP_SLVERR);
    t(OP_OR_LITERAL, 1'h0, 8'h5A, 8'hA5, 2'h0,
      8'hFF, 8'h5A, 2'h0);
    t(OP_OR_LITERAL, 1'h0, 8'h00, 8'h00, 2'h2,
      8'h00, 8'h00, 2'h3);
    t(OP_OR_REGISTER, 1'h0, 8'h0F, 8'hF0, 2'h1,
      8'hFF, 8'h0F, 2'h0);
    t(OP_OR_REGISTER, 1'h1, 8'h30, 8'h03, 2'h0,
      8'h03, 8'h33, 2'h0);
    t(OP_OR_REGISTER, 1'h1, 8'h00, 8'h00, 2'h0,
      8'h00, 8'h00, 2'h1);
    t(OP_INCREMENT, 1'h0, 8'hFF, 8'h12, 2'h0,
      8'h00, 8'hFF, 2'h1);
    t(OP_INCREMENT, 1'h1, 8'h41, 8'h77, 2'h3,
      8'h77, 8'h42, 2'h2);
    t(OP_MOVE_REGISTER, 1'h1, 8'h00, 8'h55, 2'h0,
      8'h55, 8'h00, 2'h1);
    t(OP_MOVE_REGISTER, 1'h0, 8'h80, 8'h55, 2'h1,
      8'h80, 8'h80, 2'h0);
    t(OP_LOAD_LITERAL, 1'h0, 8'hC3, 8'h00, 2'h3,
      8'hC3, 8'hC3, 2'h3);
    t(OP_STORE_ACC, 1'h0, 8'h00, 8'h9C, 2'h1,
      8'h9C, 8'h9C, 2'h1);
    t(OP_ROTATE_LEFT, 1'h0, 8'h81, 8'h00, 2'h0,
      8'h02, 8'h81, 2'h2);
    t(OP_ROTATE_LEFT, 1'h1, 8'h40, 8'h11, 2'h2,
      8'h11, 8'h81, 2'h0);
    t(OP_ROTATE_LEFT, 1'h1, 8'h00, 8'h11, 2'h3,
      8'h11, 8'h01, 2'h1);
    t(OP_NO_OPERATION, 1'h0, 8'h6E, 8'h24, 2'h3,
      8'h24, 8'h6E, 2'h3);
    axi_write(OFF_STATUS, 32'h00000000);
    axi_write(OFF_STACK_PUSH, 32'h00000ABC);
    axi_write(OFF_STACK_PUSH, 32'h00001FFF);
    rd_chk(OFF_STATUS, 32'h00000200);
    exec(OP_RETURN_LITERAL, 1'h0, 7'h00, 8'h7E);
    check(busy_len, 32'h3);
    check(pc_value, 13'h1FFF);
    check(acc_value, 8'h7E);
    exec(OP_RETURN_LITERAL, 1'h0, 7'h00, 8'h00);
    check(pc_value, 13'h0ABC);
    rd_chk(OFF_STATUS, 32'h00000000);
    axi_write(OFF_STACK_PUSH, 32'h00000123);
    exec(OP_RETURN_INTERRUPT, 1'h0, 7'h00, 8'h55);
    check(pc_value, 13'h0123);
    check(global_interrupt_enable, 1'h1);
    check(acc_value, 8'h00);
    rd_chk(OFF_STATUS, 32'h00000004);
    rd_chk(OFF_INSTR, 32'h00550008);
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: file_reg_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module file_reg_mem
  import acc_exec_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Access
  input  wire mem_req_t          req,
  output logic [DATA_W-1:0]      rdata
);

  logic [DATA_W-1:0] mem [0:(1<<FADDR_W)-1];

  always_ff @(posedge aclk) begin
    if (req.we) begin
      mem[req.waddr] <= req.wdata;
    end
  end

  // Read data is registered: it follows the read address one edge later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[req.raddr];
    end
  end

endmodule
`default_nettype wire
